// ---- include/ctxb_pkg.sv ----
// Summary of operation
// - Aborting a pending message sets that buffer's send_aborted_flag, else it reads 0.
// - Losing arbitration sets that buffer's arbitration_lost_flag, else it stays 0.
// - A bus error during sending sets that buffer's bus_error_flag, else it reads 0.
// - buffer_priority 11 is level 3 (highest) down to 00 as level 0 (lowest).
// - Among pending buffers the priority fields decide the order of sending.
// - Priority never changes the transmitted identifier bits.
// - tx_identifier_high is std id 10..3, or ext id 28..21 in extended format.
// - tx_identifier_low bits 7..5 are std id 2..0, or ext id 20..18 in extended format.
// - With extended_format_select set a 29-bit id goes out, std bits as ext 28..18.
// - With extended_format_select clear an 11-bit id goes out, ext bits 17..0 ignored.
// - Ext id bits 17..16 live in tx_identifier_low bits 1..0.
// - tx_identifier_low bits 4 and 2 read 0 and keep no written value.
// - Ext id bits 15..8 come from tx_ext_identifier_high into extended frames.
package ctxb_pkg;

   localparam int NBUF = 3;

   // Register map, byte addresses
   localparam logic [7:0] BUF_STRIDE = 8'h10;
   localparam logic [1:0] RSEL_CTRL = 2'h0;
   localparam logic [1:0] RSEL_IDH = 2'h1;
   localparam logic [1:0] RSEL_IDL = 2'h2;
   localparam logic [1:0] RSEL_EIDH = 2'h3;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h30;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h34;
   localparam int BUF_IDX_LSB = 4;
   localparam int REG_IDX_LSB = 2;

   // Control register fields
   localparam int CTRL_ABT_BIT = 6;
   localparam int CTRL_LARB_BIT = 5;
   localparam int CTRL_ERR_BIT = 4;
   localparam int CTRL_REQ_BIT = 3;
   localparam int CTRL_PRI_LSB = 0;

   // Identifier low byte fields
   localparam int IDL_SID_LSB = 5;
   localparam int IDL_EXT_BIT = 3;
   localparam int IDL_EID_LSB = 0;
   localparam logic [7:0] IDL_WMASK = 8'hEB;

   // Interrupt status layout: sent per buffer, then aborted per buffer
   localparam int IRQ_SENT_LSB = 0;
   localparam int IRQ_ABT_LSB = 3;
   localparam int IRQ_W = 6;

   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_RST = 6'h00;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;
   localparam logic [7:0] EXT_LOW_FILL = 8'h00;

   typedef enum logic [0:0] {
      PH_IDLE,
      PH_FLIGHT
   } ctxb_phase_e;

   // Offer towards the protocol engine
   typedef struct packed {
      logic valid;
      logic [1:0] buf_idx;
      logic [1:0] prio;
      logic ext;
      logic [28:0] id;
   } ctxb_offer_s;

   // Outcome strobes from the protocol engine
   typedef struct packed {
      logic start;
      logic done;
      logic lost;
      logic error;
   } ctxb_evt_s;

   typedef struct packed {
      logic [NBUF-1:0][7:0] idh;
      logic [NBUF-1:0][7:0] idl;
      logic [NBUF-1:0][7:0] eidh;
      logic [NBUF-1:0][1:0] pri;
      logic [NBUF-1:0] req;
      logic [NBUF-1:0] abt;
      logic [NBUF-1:0] larb;
      logic [NBUF-1:0] err;
      logic [NBUF-1:0] abort_pend;
      ctxb_phase_e phase;
      logic [1:0] cur;
      logic [IRQ_W-1:0] ists;
      logic [IRQ_W-1:0] imask;
      logic [31:0] prdata;
      ctxb_offer_s offer;
   } ctxb_state_s;

endpackage : ctxb_pkg

// ---- design/ctxb_pick.sv ----
// Picks the pending buffer with the highest level; ties go to the higher index
module ctxb_pick (
   // Pending requests and their levels
   input wire logic [2:0] req,
   input wire logic [2:0][1:0] pri,
   // Winner
   output logic found,
   output logic [1:0] sel,
   output logic [1:0] level
);

   // Ascending scan with >= lets a later equal-level buffer win
   always_comb begin
      found = 1'b0;
      sel = 2'b00;
      level = 2'b00;
      for (int i = 0; i < ctxb_pkg::NBUF; i++) begin
         if (req[i] && (!found || pri[i] >= level)) begin
            found = 1'b1;
            sel = 2'(i);
            level = pri[i];
         end
      end
   end

endmodule : ctxb_pick

// ---- design/ctxb_top.sv ----
// Transmit buffer control and identifier registers for three buffers
module ctxb_top (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Protocol engine
   output ctxb_pkg::ctxb_offer_s offer,
   input wire ctxb_pkg::ctxb_evt_s evt,
   // Interrupt
   output logic irq
);

   ctxb_pkg::ctxb_state_s s_q;
   ctxb_pkg::ctxb_state_s s_d;
   logic [1:0] rst_sync_q;
   logic rst_n;
   logic pick_found;
   logic [1:0] pick_sel;
   logic [1:0] pick_level;
   logic [1:0] a_buf;
   logic [1:0] a_reg;
   logic a_is_buf;
   logic a_hit;
   logic wr_acc;
   logic rd_setup;

   // Reset release through two flops, assertion stays asynchronous
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Arbitration over the committed requests
   ctxb_pick u_pick (
      .req(s_q.req),
      .pri(s_q.pri),
      .found(pick_found),
      .sel(pick_sel),
      .level(pick_level)
   );

   // Address decode
   assign a_buf = paddr[ctxb_pkg::BUF_IDX_LSB +: 2];
   assign a_reg = paddr[ctxb_pkg::REG_IDX_LSB +: 2];
   assign a_is_buf = (paddr[1:0] == 2'b00) && (paddr[7:6] == 2'b00) &&
                     (a_buf < 2'(ctxb_pkg::NBUF)); // Upper bits clear, else 0x40 aliases buffer 0
   assign a_hit = a_is_buf || (paddr == ctxb_pkg::ADDR_IRQ_STATUS) ||
                  (paddr == ctxb_pkg::ADDR_IRQ_MASK);
   assign wr_acc = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;

   // Zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && !a_hit;
   assign prdata = s_q.prdata;
   assign irq = |(s_q.ists & s_q.imask);

   // Offer is dropped at once when its buffer is no longer requested,
   // so the engine never starts a message that software just withdrew
   always_comb begin
      offer = s_q.offer;
      offer.valid = s_q.offer.valid && s_q.req[s_q.offer.buf_idx];
   end

   // Identifier assembly for one buffer; priority bits take no part
   function automatic logic [28:0] build_id(input logic [7:0] hi, input logic [7:0] lo,
                                            input logic [7:0] ehi);
      logic [28:0] id;
      id = '0;
      if (lo[ctxb_pkg::IDL_EXT_BIT]) begin
         id = {hi, lo[ctxb_pkg::IDL_SID_LSB +: 3], lo[ctxb_pkg::IDL_EID_LSB +: 2],
               ehi, ctxb_pkg::EXT_LOW_FILL};
      end else begin
         id = {18'h0_0000, hi, lo[ctxb_pkg::IDL_SID_LSB +: 3]};
      end
      return id;
   endfunction : build_id

   // Read data for one address
   function automatic logic [31:0] read_reg(input ctxb_pkg::ctxb_state_s st,
                                            input logic [7:0] addr);
      logic [31:0] d;
      logic [1:0] b;
      d = ctxb_pkg::RDATA_RST;
      b = addr[ctxb_pkg::BUF_IDX_LSB +: 2];
      if (addr == ctxb_pkg::ADDR_IRQ_STATUS) begin
         d[ctxb_pkg::IRQ_W-1:0] = st.ists;
      end else if (addr == ctxb_pkg::ADDR_IRQ_MASK) begin
         d[ctxb_pkg::IRQ_W-1:0] = st.imask;
      end else if (addr[1:0] == 2'b00 && addr[7:6] == 2'b00 && b < 2'(ctxb_pkg::NBUF)) begin
         case (addr[ctxb_pkg::REG_IDX_LSB +: 2])
            ctxb_pkg::RSEL_CTRL: begin
               d[ctxb_pkg::CTRL_ABT_BIT] = st.abt[b];
               d[ctxb_pkg::CTRL_LARB_BIT] = st.larb[b];
               d[ctxb_pkg::CTRL_ERR_BIT] = st.err[b];
               d[ctxb_pkg::CTRL_REQ_BIT] = st.req[b];
               d[ctxb_pkg::CTRL_PRI_LSB +: 2] = st.pri[b];
            end
            ctxb_pkg::RSEL_IDH: d[7:0] = st.idh[b];
            ctxb_pkg::RSEL_IDL: d[7:0] = st.idl[b] & ctxb_pkg::IDL_WMASK;
            ctxb_pkg::RSEL_EIDH: d[7:0] = st.eidh[b];
            default: d = ctxb_pkg::RDATA_RST;
         endcase
      end
      return d;
   endfunction : read_reg

   // Next state: software first, then hardware events so a set wins
   always_comb begin
      logic [ctxb_pkg::IRQ_W-1:0] iset;
      logic in_flight;
      logic [1:0] c;
      iset = '0;
      in_flight = 1'b0;
      c = 2'b00;
      s_d = s_q;

      // Read data is captured in the setup phase, stable for the access
      if (rd_setup) begin
         s_d.prdata = read_reg(s_q, paddr);
      end

      // Register writes
      if (wr_acc && a_is_buf) begin
         case (a_reg)
            ctxb_pkg::RSEL_CTRL: begin
               s_d.pri[a_buf] = pwdata[ctxb_pkg::CTRL_PRI_LSB +: 2];
               in_flight = (s_q.phase == ctxb_pkg::PH_FLIGHT && s_q.cur == a_buf) ||
                           (evt.start && offer.valid && s_q.offer.buf_idx == a_buf);
               if (pwdata[ctxb_pkg::CTRL_REQ_BIT] && !s_q.req[a_buf]) begin
                  // New request clears the outcome of the last one
                  s_d.req[a_buf] = 1'b1;
                  s_d.abt[a_buf] = 1'b0;
                  s_d.larb[a_buf] = 1'b0;
                  s_d.err[a_buf] = 1'b0;
                  s_d.abort_pend[a_buf] = 1'b0;
               end else if (!pwdata[ctxb_pkg::CTRL_REQ_BIT] && s_q.req[a_buf]) begin
                  if (in_flight) begin
                     // A frame on the wire finishes; abort takes effect after it only if the frame is lost or errors
                     s_d.abort_pend[a_buf] = 1'b1;
                  end else begin
                     s_d.req[a_buf] = 1'b0;
                     s_d.abt[a_buf] = 1'b1;
                     iset[ctxb_pkg::IRQ_ABT_LSB + 32'(a_buf)] = 1'b1;
                  end
               end
            end
            ctxb_pkg::RSEL_IDH: s_d.idh[a_buf] = pwdata[7:0];
            ctxb_pkg::RSEL_IDL: s_d.idl[a_buf] = pwdata[7:0] & ctxb_pkg::IDL_WMASK;
            ctxb_pkg::RSEL_EIDH: s_d.eidh[a_buf] = pwdata[7:0];
            default: s_d.idh[a_buf] = s_q.idh[a_buf];
         endcase
      end
      if (wr_acc && paddr == ctxb_pkg::ADDR_IRQ_STATUS) begin
         s_d.ists = s_q.ists & ~pwdata[ctxb_pkg::IRQ_W-1:0];
      end
      if (wr_acc && paddr == ctxb_pkg::ADDR_IRQ_MASK) begin
         s_d.imask = pwdata[ctxb_pkg::IRQ_W-1:0];
      end

      // Engine outcome for the buffer in flight
      c = s_q.cur;
      case (s_q.phase)
         ctxb_pkg::PH_IDLE: begin
            if (evt.start && offer.valid) begin
               s_d.phase = ctxb_pkg::PH_FLIGHT;
               s_d.cur = s_q.offer.buf_idx;
            end
         end
         ctxb_pkg::PH_FLIGHT: begin
            if (evt.done) begin
               s_d.req[c] = 1'b0;
               s_d.abort_pend[c] = 1'b0;
               iset[ctxb_pkg::IRQ_SENT_LSB + 32'(c)] = 1'b1;
               s_d.phase = ctxb_pkg::PH_IDLE;
            end else if (evt.lost || evt.error) begin
               if (evt.lost) begin
                  s_d.larb[c] = 1'b1;
               end
               if (evt.error) begin
                  s_d.err[c] = 1'b1;
               end
               // Request stays for a retry unless software withdrew it
               if (s_q.abort_pend[c] || s_d.abort_pend[c]) begin
                  s_d.req[c] = 1'b0;
                  s_d.abt[c] = 1'b1;
                  s_d.abort_pend[c] = 1'b0;
                  iset[ctxb_pkg::IRQ_ABT_LSB + 32'(c)] = 1'b1;
               end
               s_d.phase = ctxb_pkg::PH_IDLE;
            end
         end
         default: s_d.phase = ctxb_pkg::PH_IDLE;
      endcase
      s_d.ists = s_d.ists | iset;

      // Registered offer; re-picked whenever no frame is on the wire
      s_d.offer.valid = 1'b0;
      if (s_d.phase == ctxb_pkg::PH_IDLE && !(s_q.phase == ctxb_pkg::PH_IDLE && evt.start)) begin
         s_d.offer.valid = pick_found;
      end
      s_d.offer.buf_idx = pick_sel;
      s_d.offer.prio = pick_level;
      s_d.offer.ext = s_q.idl[pick_sel][ctxb_pkg::IDL_EXT_BIT];
      s_d.offer.id = build_id(s_q.idh[pick_sel], s_q.idl[pick_sel],
                              s_q.eidh[pick_sel]);
   end

   // State register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule : ctxb_top

// ---- testbench/ctxb_monitor.sv ----
module ctxb_monitor (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Engine side and interrupt
   input wire ctxb_pkg::ctxb_offer_s offer,
   input wire ctxb_pkg::ctxb_evt_s evt,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   logic [3:0][7:0] hi_q, lo_q, ex_q;
   logic [3:0][1:0] pr_q;
   logic [1:0] quiet_q;
   logic wr, rd, unm;
   logic [7:0] h, l, e;
   // Strobes and the shadow bytes of the offered buffer
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite && paddr[7:4] < 4'h3 && paddr[1:0] == 2'h0;
   assign unm = psel && penable && (paddr > 8'h34 || paddr[1:0] != 2'h0);
   assign h = hi_q[offer.buf_idx];
   assign l = lo_q[offer.buf_idx];
   assign e = ex_q[offer.buf_idx];
   // Shadow of written bytes; quiet_q gives a fresh write time to reach the offer
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         hi_q <= '0;
         lo_q <= '0;
         ex_q <= '0;
         pr_q <= '0;
         quiet_q <= 2'h0;
      end else if (wr) begin
         quiet_q <= 2'h0;
         if (paddr[3:0] == 4'h0) pr_q[paddr[5:4]] <= pwdata[1:0];
         if (paddr[3:0] == 4'h4) hi_q[paddr[5:4]] <= pwdata[7:0];
         if (paddr[3:0] == 4'h8) lo_q[paddr[5:4]] <= pwdata[7:0];
         if (paddr[3:0] == 4'hC) ex_q[paddr[5:4]] <= pwdata[7:0];
      end else if (quiet_q != 2'h3) begin
         quiet_q <= quiet_q + 2'h1;
      end
   end
   a_std_id:
      assert property (offer.valid && !offer.ext && quiet_q[1] |-> offer.id == {h, l[7:5]})
      else $error("standard id wrong");
   a_ext_id:
      assert property (offer.valid && offer.ext && quiet_q[1]
         |-> offer.id == {h, l[7:5], l[1:0], e, 8'h00}) else $error("extended id wrong");
   a_ext_flag:
      assert property (offer.valid && quiet_q[1] |-> offer.ext == l[3]) else $error("ext flag");
   a_prio_code:
      assert property (offer.valid && quiet_q[1] |-> offer.prio == pr_q[offer.buf_idx])
      else $error("offer priority wrong");
   a_start_drop:
      assert property (offer.valid && evt.start |=> !offer.valid) else $error("offer kept");
   a_offer_holds:
      assert property (offer.valid && !evt.start && !wr && quiet_q[1]
         |=> !offer.valid || $stable(offer.id)) else $error("offer id moved");
   a_idl_holes:
      assert property (rd && paddr[3:0] == 4'h8 |-> prdata[4] == 1'b0 && prdata[2] == 1'b0)
      else $error("id low hole set");
   a_ctrl_holes:
      assert property (rd && paddr[3:0] == 4'h0 |-> prdata[7] == 1'b0 && prdata[2] == 1'b0)
      else $error("control hole set");
   a_bad_addr:
      assert property (unm |-> pslverr && (pwrite || prdata == 32'h0000_0000))
      else $error("unmapped");
   a_zero_wait:
      assert property (psel && penable |-> pready) else $error("pready low in access");
   c_ext: cover property (offer.valid && offer.ext);
   c_lost: cover property (evt.lost);
   c_err: cover property (evt.error);
endmodule : ctxb_monitor

bind ctxb_top ctxb_monitor i_mon (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .offer(offer), .evt(evt), .irq(irq));

// ---- testbench/ctxb_engine.sv ----
module ctxb_engine (
   // Clock, reset and bench control
   input wire logic mclk,
   input wire logic rstn,
   input wire logic go,
   input wire logic [1:0] mode,
   input wire logic [3:0] lat,
   // Protocol side
   input wire ctxb_pkg::ctxb_offer_s offer,
   output ctxb_pkg::ctxb_evt_s evt
);
   timeunit 1ns;
   timeprecision 1ns;
   logic busy;
   logic [3:0] cnt;
   // One frame at a time; go lets the bench stall so requests pile up
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         busy <= 1'b0;
         cnt <= 4'h0;
         evt <= '0;
      end else begin
         evt <= '0;
         if (!busy && go && offer.valid) begin
            evt.start <= 1'b1;
            busy <= 1'b1;
            cnt <= lat;
         end else if (busy && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end else if (busy) begin
            busy <= 1'b0;
            evt.done <= (mode == 2'h0);
            evt.lost <= (mode == 2'h1);
            evt.error <= (mode == 2'h2);
         end
      end
   end
endmodule : ctxb_engine

// ---- testbench/testbench.sv ----
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, rstn, psel, penable, pwrite, pready, pslverr, irq, go, serr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [1:0] mode;
   logic [3:0] lat;
   ctxb_pkg::ctxb_offer_s offer;
   ctxb_pkg::ctxb_evt_s evt;
   int n_errors, total_checks;
   ctxb_top i_dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .offer(offer), .evt(evt), .irq(irq));
   ctxb_engine i_eng (.mclk(mclk), .rstn(rstn), .go(go), .mode(mode), .lat(lat),
      .offer(offer), .evt(evt));
   // 50 ns system clock
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Setup, access until pready, then one idle cycle so psel never toggles twice at once
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rdata = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb
   task rd(input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      chk("read", {24'h00_0000, exp}, rdata);
   endtask : rd
   // Bounded wait for strobe k: 3 start, 2 done, 1 lost, 0 error
   task wait_evt(input int k);
      int i;
      for (i = 0; i < 300 && evt[k] !== 1'b1; i++) @(posedge mclk);
      if (i == 300) chk("event", 1, 0);
   endtask : wait_evt
   task t_regs;
      rd(8'h20, 8'h00);
      apb(1'b1, 8'h20, 8'hF7);
      rd(8'h20, 8'h03);
      apb(1'b1, 8'h28, 8'hFF);
      rd(8'h28, 8'hEB);
      apb(1'b0, 8'h3C, 8'h00);
      chk("slverr", 1, serr);
      apb(1'b1, 8'h40, 8'h03);
      chk("slverr high", 1, serr);
      rd(8'h00, 8'h00);
   endtask : t_regs
   task t_std;
      apb(1'b1, 8'h04, 8'hA5);
      apb(1'b1, 8'h08, 8'hE3);
      apb(1'b1, 8'h0C, 8'hFF);
      rd(8'h04, 8'hA5);
      rd(8'h08, 8'hE3);
      rd(8'h0C, 8'hFF);
      apb(1'b1, 8'h00, 8'h0A);
      wait_evt(3);
      chk("std id", 32'h0000_052F, offer.id);
      wait_evt(2);
      rd(8'h00, 8'h02);
      chk("irq masked", 0, irq);
      apb(1'b1, 8'h34, 8'h01);
      chk("irq", 1, irq);
      apb(1'b1, 8'h30, 8'h01);
      chk("irq clear", 0, irq);
   endtask : t_std
   task t_fail;
      mode <= 2'h1;
      apb(1'b1, 8'h14, 8'h5A);
      apb(1'b1, 8'h18, 8'h4A);
      apb(1'b1, 8'h1C, 8'hC3);
      apb(1'b1, 8'h10, 8'h09);
      wait_evt(3);
      chk("ext id", 32'h0B4A_C300, offer.id);
      wait_evt(1);
      go <= 1'b0;
      rd(8'h10, 8'h29);
      apb(1'b1, 8'h10, 8'h01);
      rd(8'h10, 8'h61);
      rd(8'h30, 8'h10);
      go <= 1'b1;
      mode <= 2'h2;
      lat <= 4'h8;
      apb(1'b1, 8'h10, 8'h09);
      wait_evt(3);
      apb(1'b1, 8'h10, 8'h01);
      wait_evt(0);
      rd(8'h10, 8'h51);
      apb(1'b1, 8'h30, 8'h3F);
   endtask : t_fail
   // Queue all three with the engine stalled, then check the order of starts
   task t_order(input logic [5:0] p, input logic [5:0] e);
      int i;
      go <= 1'b0;
      mode <= 2'h0;
      lat <= 4'h1;
      for (i = 0; i < 3; i++) apb(1'b1, 8'(i * 16), {6'h02, p[2*i+:2]});
      go <= 1'b1;
      for (i = 0; i < 3; i++) begin
         wait_evt(3);
         chk("winner", e[2*i+:2], offer.buf_idx);
         wait_evt(2);
      end
   endtask : t_order
   // Sent bits from the ordering runs, then a mid-run reset clears everything
   task t_reset;
      rd(8'h30, 8'h07);
      chk("irq sent", 1, irq);
      rstn <= 1'b0;
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      repeat (6) @(posedge mclk);
      rd(8'h30, 8'h00);
      rd(8'h00, 8'h00);
      chk("irq reset", 0, irq);
   endtask : t_reset
   task end_sim;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   // Main sequence
   initial begin
      {rstn, psel, penable, pwrite, go} = 5'h01;
      {paddr, pwdata, mode, lat} = {8'h00, 32'h0000_0000, 2'h0, 4'h3};
      n_errors = 0;
      total_checks = 0;
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      repeat (6) @(posedge mclk);
      t_regs();
      t_std();
      t_fail();
      t_order(6'b01_10_11, 6'b10_01_00);
      t_order(6'b01_01_11, 6'b01_10_00);
      t_reset();
      end_sim();
   end
   // Watchdog
   initial begin
      repeat (5000) @(posedge mclk);
      chk("watchdog", 1, 0);
      end_sim();
   end
endmodule : testbench
